/* File: design/dual_comparator_control.sv */
// Top of the dual comparator control block: SFR decode, input
// synchronisers and two channels.
// Assumes the analog stage supplies raw comparison results per channel
// and applies the select and hysteresis codes driven here.
//
// Notes on behaviour
// - Two channels share identical control logic; only input pins and reset differ.
// - Each channel drives a raw unclocked output and a clock-latched output.
// - Channel zero output can be selected as a system reset source.
// - A disabled channel drives its pin outputs low.
// - Control bit 7 enables the channel when one.
// - Read-only bit 6 shows the current comparison result while enabled, zero when disabled.
// - Falling edge sets bit 4; rising edge sets bit 5.
// - Edge flags stay set until software writes zero.
// - Rising and falling transitions can request an interrupt.
// - Control bits 3:2 select positive hysteresis for the analog stage.
// - Control bits 1:0 select negative hysteresis, same encoding.
// - Channel zero negative select bits 5:4 pick P1.1, P1.5, P2.1, P2.5.
// - Channel zero positive select bits 1:0 pick P1.0, P1.4, P2.0, P2.4.
// - Channel one negative select bits 5:4 pick P1.3, P1.7, P2.3, P2.7.
// - Channel one positive select bits 1:0 pick P1.2, P1.6, P2.2, P2.6.
// - Unused mux bits read zero and ignore writes.
// - Mode bits 5 and 4 enable rising and falling interrupts.
// - Mode bits 1:0 choose response time; mode resets to two.
`timescale 1ns/10ps
`include "cmp_defs.svh"
module dual_comparator_control (
    input  wire logic               core_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               sfr_wr_i,
    input  wire logic               sfr_rd_i,
    input  wire cmp_pkg::sfr_byte_t sfr_addr_i,
    input  wire cmp_pkg::sfr_byte_t sfr_wdata_i,
    output cmp_pkg::sfr_byte_t      sfr_rdata_o,
    output logic                    sfr_hit_o,
    input  wire logic               ch0_cmp_i,
    input  wire logic               ch1_cmp_i,
    input  wire logic               ch0_reset_sel_i,
    output logic                    ch0_reset_req_o,
    output logic                    ch0_latched_output_o,
    output logic                    ch1_latched_output_o,
    output logic                    ch0_raw_output_o,
    output logic                    ch1_raw_output_o,
    output logic                    ch0_enable_o,
    output logic                    ch1_enable_o,
    output logic                    cmp_irq_o,
    output cmp_pkg::sel2_t          ch0_pos_hyst_o,
    output cmp_pkg::sel2_t          ch0_neg_hyst_o,
    output cmp_pkg::sel2_t          ch1_pos_hyst_o,
    output cmp_pkg::sel2_t          ch1_neg_hyst_o,
    output cmp_pkg::sel2_t          ch0_resp_time_o,
    output cmp_pkg::sel2_t          ch1_resp_time_o,
    output logic [3:0]              ch0_pos_pin_o,
    output logic [3:0]              ch0_neg_pin_o,
    output logic [3:0]              ch1_pos_pin_o,
    output logic [3:0]              ch1_neg_pin_o
);
    import cmp_pkg::*;

    // One-hot pin select; bit n picks the n-th pin of the four listed per field
    function automatic logic [3:0] pin_onehot(input sel2_t code);
        case (mux_code_t'(code))
            sel_code0: pin_onehot = 4'h1;
            sel_code1: pin_onehot = 4'h2;
            sel_code2: pin_onehot = 4'h4;
            sel_code3: pin_onehot = 4'h8;
            default:   pin_onehot = 4'h0;
        endcase
    endfunction : pin_onehot

    // ====================================================================
    // Address decode
    logic      hit_c0;
    logic      hit_c1;
    logic      hit_m0;
    logic      hit_m1;
    logic      hit_x0;
    logic      hit_x1;
    sfr_byte_t c0_rd;
    sfr_byte_t c1_rd;
    sfr_byte_t m0_rd;
    sfr_byte_t m1_rd;
    sfr_byte_t x0_rd;
    sfr_byte_t x1_rd;
    sel2_t     p0_sel;
    sel2_t     n0_sel;
    sel2_t     p1_sel;
    sel2_t     n1_sel;
    logic      irq0;
    logic      irq1;
    logic      ch0_sync;
    logic      ch1_sync;
    sfr_byte_t rdata_next;

    assign hit_c0 = (sfr_addr_i == `CH0_CTRL_ADDR);
    assign hit_c1 = (sfr_addr_i == `CH1_CTRL_ADDR);
    assign hit_m0 = (sfr_addr_i == `CH0_MODE_ADDR);
    assign hit_m1 = (sfr_addr_i == `CH1_MODE_ADDR);
    assign hit_x0 = (sfr_addr_i == `CH0_MUX_ADDR);
    assign hit_x1 = (sfr_addr_i == `CH1_MUX_ADDR);
    assign sfr_hit_o = hit_c0 | hit_c1 | hit_m0 | hit_m1 | hit_x0 | hit_x1;

    // Unmapped addresses read as zero
    assign rdata_next = hit_c0 ? c0_rd :
                        hit_c1 ? c1_rd :
                        hit_m0 ? m0_rd :
                        hit_m1 ? m1_rd :
                        hit_x0 ? x0_rd :
                        hit_x1 ? x1_rd : `BYTE_ZERO;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            sfr_rdata_o <= `BYTE_ZERO;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= rdata_next;
        end
    end

    // ====================================================================
    // Input synchronisers: raw pins stay asynchronous, while flags and
    // latched outputs only ever see these two-flop copies
    cmp_sync u_sync0 (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    (ch0_cmp_i),
        .sync_o     (ch0_sync)
    );

    cmp_sync u_sync1 (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    (ch1_cmp_i),
        .sync_o     (ch1_sync)
    );

    // ====================================================================
    // Channels: identical instances
    cmp_channel u_ch0 (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .raw_cmp_i   (ch0_cmp_i),
        .sync_cmp_i  (ch0_sync),
        .ctrl_we_i   (sfr_wr_i & hit_c0),
        .mode_we_i   (sfr_wr_i & hit_m0),
        .mux_we_i    (sfr_wr_i & hit_x0),
        .wdata_i     (sfr_wdata_i),
        .ctrl_rd_o   (c0_rd),
        .mode_rd_o   (m0_rd),
        .mux_rd_o    (x0_rd),
        .enable_o    (ch0_enable_o),
        .latched_o   (ch0_latched_output_o),
        .raw_pin_o   (ch0_raw_output_o),
        .irq_o       (irq0),
        .pos_hyst_o  (ch0_pos_hyst_o),
        .neg_hyst_o  (ch0_neg_hyst_o),
        .resp_time_o (ch0_resp_time_o),
        .pos_sel_o   (p0_sel),
        .neg_sel_o   (n0_sel)
    );

    cmp_channel u_ch1 (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .raw_cmp_i   (ch1_cmp_i),
        .sync_cmp_i  (ch1_sync),
        .ctrl_we_i   (sfr_wr_i & hit_c1),
        .mode_we_i   (sfr_wr_i & hit_m1),
        .mux_we_i    (sfr_wr_i & hit_x1),
        .wdata_i     (sfr_wdata_i),
        .ctrl_rd_o   (c1_rd),
        .mode_rd_o   (m1_rd),
        .mux_rd_o    (x1_rd),
        .enable_o    (ch1_enable_o),
        .latched_o   (ch1_latched_output_o),
        .raw_pin_o   (ch1_raw_output_o),
        .irq_o       (irq1),
        .pos_hyst_o  (ch1_pos_hyst_o),
        .neg_hyst_o  (ch1_neg_hyst_o),
        .resp_time_o (ch1_resp_time_o),
        .pos_sel_o   (p1_sel),
        .neg_sel_o   (n1_sel)
    );

    // ====================================================================
    // Pin selection, reset path and interrupt
    // Code 3 is still decoded; on the small package software must avoid it
    assign ch0_neg_pin_o = pin_onehot(n0_sel);
    assign ch0_pos_pin_o = pin_onehot(p0_sel);
    assign ch1_neg_pin_o = pin_onehot(n1_sel);
    assign ch1_pos_pin_o = pin_onehot(p1_sel);

    // Reset source uses the latched output so glitches cannot reset the chip
    assign ch0_reset_req_o = ch0_reset_sel_i & ch0_latched_output_o;
    assign cmp_irq_o = irq0 | irq1;

    reset_path_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ch0_reset_req_o |-> ch0_enable_o && ch0_reset_sel_i)
        else $error("reset request without enable and select");
    pin_onehot_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $onehot(ch0_neg_pin_o) && $onehot(ch0_pos_pin_o)
        && $onehot(ch1_neg_pin_o) && $onehot(ch1_pos_pin_o))
        else $error("pin select not one-hot");
    ch0_pin_map_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ch0_neg_pin_o[x0_rd[`MUX_NEG_HI:`MUX_NEG_LO]]
        && ch0_pos_pin_o[x0_rd[`MUX_POS_HI:`MUX_POS_LO]])
        else $error("channel zero pin does not follow its code");
    ch1_pin_map_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ch1_neg_pin_o[x1_rd[`MUX_NEG_HI:`MUX_NEG_LO]]
        && ch1_pos_pin_o[x1_rd[`MUX_POS_HI:`MUX_POS_LO]])
        else $error("channel one pin does not follow its code");
    ch0_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !ch0_enable_o |-> !ch0_raw_output_o && !ch0_latched_output_o)
        else $error("channel zero output high while disabled");
    ch1_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !ch1_enable_o |-> !ch1_raw_output_o && !ch1_latched_output_o)
        else $error("channel one output high while disabled");
    state_bit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (!ch0_enable_o || c0_rd[`CTRL_OUT_BIT] == ch0_sync)
        && (!ch1_enable_o || c1_rd[`CTRL_OUT_BIT] == ch1_sync))
        else $error("output state bit does not follow comparison");
    hyst_pass_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ch0_pos_hyst_o == c0_rd[`CTRL_HYP_HI:`CTRL_HYP_LO]
        && ch0_neg_hyst_o == c0_rd[`CTRL_HYN_HI:`CTRL_HYN_LO]
        && ch1_pos_hyst_o == c1_rd[`CTRL_HYP_HI:`CTRL_HYP_LO]
        && ch1_neg_hyst_o == c1_rd[`CTRL_HYN_HI:`CTRL_HYN_LO])
        else $error("hysteresis code differs from control register");
    resp_pass_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ch0_resp_time_o == m0_rd[`MODE_RT_HI:`MODE_RT_LO]
        && ch1_resp_time_o == m1_rd[`MODE_RT_HI:`MODE_RT_LO])
        else $error("response time differs from mode register");
    ch1_no_reset_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !ch0_latched_output_o |-> !ch0_reset_req_o)
        else $error("reset request not from channel zero");
    irq_source_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        cmp_irq_o |-> c0_rd[`CTRL_RISE_BIT] || c0_rd[`CTRL_FALL_BIT]
                      || c1_rd[`CTRL_RISE_BIT] || c1_rd[`CTRL_FALL_BIT])
        else $error("interrupt without edge flag");
endmodule : dual_comparator_control

/* File: design/cmp_defs.svh */
// Register offsets, field positions, reset values and write masks for the
// dual comparator control block. Assumes an 8-bit special-function bus.
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

`define CH1_CTRL_ADDR     8'h9a
`define CH0_CTRL_ADDR     8'h9b
`define CH1_MODE_ADDR     8'h9c
`define CH0_MODE_ADDR     8'h9d
`define CH1_MUX_ADDR      8'h9e
`define CH0_MUX_ADDR      8'h9f

`define CTRL_EN_BIT       7
`define CTRL_OUT_BIT      6
`define CTRL_RISE_BIT     5
`define CTRL_FALL_BIT     4
`define CTRL_HYP_HI       3
`define CTRL_HYP_LO       2
`define CTRL_HYN_HI       1
`define CTRL_HYN_LO       0

`define MODE_RIE_BIT      5
`define MODE_FIE_BIT      4
`define MODE_RT_HI        1
`define MODE_RT_LO        0

`define MUX_NEG_HI        5
`define MUX_NEG_LO        4
`define MUX_POS_HI        1
`define MUX_POS_LO        0
`define MUX_WRITE_MASK    8'h33
`define MODE_WRITE_MASK   8'h33

`define CTRL_RESET        8'h00
`define MUX_RESET         8'h00
`define MODE_RESET        8'h02
`define BYTE_ZERO         8'h00

`endif

/* File: design/cmp_pkg.sv */
// Shared types for the dual comparator control block.
// Assumes cmp_defs.svh supplies all numeric constants.
package cmp_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [1:0] sel2_t;
    typedef enum logic [1:0] {
        sel_code0,
        sel_code1,
        sel_code2,
        sel_code3
    } mux_code_t;
endpackage : cmp_pkg

/* File: design/cmp_sync.sv */
// Two-flip-flop synchroniser for one raw comparator output.
// Assumes a single system clock and synchronous active-low reset.
`timescale 1ns/10ps
module cmp_sync (
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_reg;
    logic sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule : cmp_sync

/* File: design/cmp_channel.sv */
// One comparator channel: control, mode and mux registers, output latch,
// edge flags and interrupt request. Assumes the top decodes addresses
// and hands in the two-flop synchronised comparison.
`timescale 1ns/10ps
`include "cmp_defs.svh"
module cmp_channel (
    input  wire logic               core_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               raw_cmp_i,
    input  wire logic               sync_cmp_i,
    input  wire logic               ctrl_we_i,
    input  wire logic               mode_we_i,
    input  wire logic               mux_we_i,
    input  wire cmp_pkg::sfr_byte_t wdata_i,
    output cmp_pkg::sfr_byte_t      ctrl_rd_o,
    output cmp_pkg::sfr_byte_t      mode_rd_o,
    output cmp_pkg::sfr_byte_t      mux_rd_o,
    output logic                    enable_o,
    output logic                    latched_o,
    output logic                    raw_pin_o,
    output logic                    irq_o,
    output cmp_pkg::sel2_t          pos_hyst_o,
    output cmp_pkg::sel2_t          neg_hyst_o,
    output cmp_pkg::sel2_t          resp_time_o,
    output cmp_pkg::sel2_t          pos_sel_o,
    output cmp_pkg::sel2_t          neg_sel_o
);
    import cmp_pkg::*;

    sfr_byte_t ctrl_reg;
    sfr_byte_t mode_reg;
    sfr_byte_t mux_reg;
    logic      sync_val;
    logic      prev_reg;
    logic      rise_evt;
    logic      fall_evt;
    logic      rise_next;
    logic      fall_next;
    logic      enable_next;

    // Synchronised at the top so the raw path never meets flag logic
    assign sync_val    = sync_cmp_i;

    assign enable_o    = ctrl_reg[`CTRL_EN_BIT];
    // Next enable, so the latched pin drops in the same cycle as the enable
    assign enable_next = ctrl_we_i ? wdata_i[`CTRL_EN_BIT] : ctrl_reg[`CTRL_EN_BIT];
    assign rise_evt    = enable_o & sync_val & ~prev_reg;
    assign fall_evt    = enable_o & ~sync_val & prev_reg;
    // Set beats a same-cycle software clear
    assign rise_next   = rise_evt | (ctrl_we_i ? wdata_i[`CTRL_RISE_BIT]
                                               : ctrl_reg[`CTRL_RISE_BIT]);
    assign fall_next   = fall_evt | (ctrl_we_i ? wdata_i[`CTRL_FALL_BIT]
                                               : ctrl_reg[`CTRL_FALL_BIT]);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ctrl_reg  <= `CTRL_RESET;
            mode_reg  <= `MODE_RESET;
            mux_reg   <= `MUX_RESET;
            prev_reg  <= 1'b0;
            latched_o <= 1'b0;
        end else begin
            prev_reg  <= sync_val;
            latched_o <= enable_next & sync_val;
            ctrl_reg[`CTRL_RISE_BIT] <= rise_next;
            ctrl_reg[`CTRL_FALL_BIT] <= fall_next;
            ctrl_reg[`CTRL_OUT_BIT]  <= 1'b0;
            if (ctrl_we_i) begin
                ctrl_reg[`CTRL_EN_BIT] <= wdata_i[`CTRL_EN_BIT];
                ctrl_reg[`CTRL_HYP_HI:`CTRL_HYN_LO] <= wdata_i[`CTRL_HYP_HI:`CTRL_HYN_LO];
            end
            if (mode_we_i) begin
                mode_reg <= wdata_i & `MODE_WRITE_MASK;
            end
            if (mux_we_i) begin
                mux_reg <= wdata_i & `MUX_WRITE_MASK;
            end
        end
    end

    // Output state bit reads live synchronised comparison ANDed with the enable bit
    assign ctrl_rd_o   = {ctrl_reg[`CTRL_EN_BIT], sync_val & enable_o,
                          ctrl_reg[`CTRL_RISE_BIT:`CTRL_HYN_LO]};
    assign mode_rd_o   = mode_reg;
    assign mux_rd_o    = mux_reg;
    assign raw_pin_o   = enable_o & raw_cmp_i;
    assign irq_o       = (ctrl_reg[`CTRL_RISE_BIT] & mode_reg[`MODE_RIE_BIT])
                       | (ctrl_reg[`CTRL_FALL_BIT] & mode_reg[`MODE_FIE_BIT]);
    assign pos_hyst_o  = ctrl_reg[`CTRL_HYP_HI:`CTRL_HYP_LO];
    assign neg_hyst_o  = ctrl_reg[`CTRL_HYN_HI:`CTRL_HYN_LO];
    assign resp_time_o = mode_reg[`MODE_RT_HI:`MODE_RT_LO];
    assign pos_sel_o   = mux_reg[`MUX_POS_HI:`MUX_POS_LO];
    assign neg_sel_o   = mux_reg[`MUX_NEG_HI:`MUX_NEG_LO];

    sticky_rise_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ctrl_reg[`CTRL_RISE_BIT] && !(ctrl_we_i && !wdata_i[`CTRL_RISE_BIT])
        |=> ctrl_reg[`CTRL_RISE_BIT])
        else $error("rising flag dropped without clear");
    sticky_fall_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ctrl_reg[`CTRL_FALL_BIT] && !(ctrl_we_i && !wdata_i[`CTRL_FALL_BIT])
        |=> ctrl_reg[`CTRL_FALL_BIT])
        else $error("falling flag dropped without clear");
    set_wins_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rise_evt |=> ctrl_reg[`CTRL_RISE_BIT])
        else $error("rising edge lost");
    fall_set_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        enable_o && prev_reg && !sync_val |=> ctrl_reg[`CTRL_FALL_BIT])
        else $error("falling edge not flagged");
    disabled_low_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !enable_o |-> !raw_pin_o && !latched_o)
        else $error("disabled output not low");
    irq_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        irq_o |-> (mode_reg[`MODE_RIE_BIT] || mode_reg[`MODE_FIE_BIT]))
        else $error("irq without enable");
    mux_clean_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (mux_reg & ~`MUX_WRITE_MASK) == `BYTE_ZERO)
        else $error("unused mux bits set");
endmodule : cmp_channel

/* File: verif/dual_comparator_control_tb.sv */
// Self-checking bench for the dual comparator control block.
// Assumes the SFR strobes are sampled on the rising clock edge and that
// cmp_defs.svh is on the include path.
`timescale 1ns/10ps
`include "cmp_defs.svh"
module dual_comparator_control_tb;
    import cmp_pkg::*;

    // ==================================================================
    // Signals
    logic       core_clk_i;
    logic       rstn_i;
    logic       sfr_wr_i;
    logic       sfr_rd_i;
    sfr_byte_t  sfr_addr_i;
    sfr_byte_t  sfr_wdata_i;
    sfr_byte_t  sfr_rdata_o;
    logic       sfr_hit_o;
    logic [1:0] cmp_in;
    logic       ch0_reset_sel_i;
    logic       reset_req;
    logic [1:0] lat;
    logic [1:0] raw;
    logic [1:0] en;
    logic       irq;
    sel2_t      pos_hyst [2];
    sel2_t      neg_hyst [2];
    sel2_t      resp     [2];
    logic [3:0] pos_pin  [2];
    logic [3:0] neg_pin  [2];
    int         n_errors;
    int         checked;

    dual_comparator_control i_dual_comparator_control (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
        .ch0_cmp_i(cmp_in[0]), .ch1_cmp_i(cmp_in[1]),
        .ch0_reset_sel_i(ch0_reset_sel_i), .ch0_reset_req_o(reset_req),
        .ch0_latched_output_o(lat[0]), .ch1_latched_output_o(lat[1]),
        .ch0_raw_output_o(raw[0]), .ch1_raw_output_o(raw[1]),
        .ch0_enable_o(en[0]), .ch1_enable_o(en[1]), .cmp_irq_o(irq),
        .ch0_pos_hyst_o(pos_hyst[0]), .ch0_neg_hyst_o(neg_hyst[0]),
        .ch1_pos_hyst_o(pos_hyst[1]), .ch1_neg_hyst_o(neg_hyst[1]),
        .ch0_resp_time_o(resp[0]), .ch1_resp_time_o(resp[1]),
        .ch0_pos_pin_o(pos_pin[0]), .ch0_neg_pin_o(neg_pin[0]),
        .ch1_pos_pin_o(pos_pin[1]), .ch1_neg_pin_o(neg_pin[1])
    );

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // ==================================================================
    // Access tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
        @(posedge core_clk_i);
        sfr_wr_i    <= 1'b1;
        sfr_addr_i  <= a;
        sfr_wdata_i <= d;
        @(posedge core_clk_i);
        sfr_wr_i <= 1'b0;
        #1;
    endtask : wr

    // Read data is registered, so it is taken one edge after the strobe edge
    task automatic rd_chk(input sfr_byte_t a, input sfr_byte_t exp);
        @(posedge core_clk_i);
        sfr_rd_i   <= 1'b1;
        sfr_addr_i <= a;
        @(posedge core_clk_i);
        sfr_rd_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        check(sfr_rdata_o, exp);
    endtask : rd_chk

    task automatic end_of_test;
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // ==================================================================
    // Edge flags, interrupt gating and enable behaviour of one channel
    task automatic edge_run(input int ch);
        sfr_byte_t ca;
        sfr_byte_t ma;
        ca = (ch == 1) ? `CH1_CTRL_ADDR : `CH0_CTRL_ADDR;
        ma = (ch == 1) ? `CH1_MODE_ADDR : `CH0_MODE_ADDR;
        wr(ca, 8'h80);
        check(en[ch], 1'b1);
        @(posedge core_clk_i);
        cmp_in[ch] <= 1'b1;
        #1;
        check(raw[ch], 1'b1);
        check(lat[ch], 1'b0);
        repeat (4) @(posedge core_clk_i);
        #1;
        check(lat[ch], 1'b1);
        check(irq, 1'b0);
        rd_chk(ca, 8'he0);
        ch0_reset_sel_i <= 1'b1;
        wr(ma, 8'h22);
        check(irq, 1'b1);
        check(reset_req, (ch == 0) ? 1'b1 : 1'b0);
        ch0_reset_sel_i <= 1'b0;
        wr(ca, 8'h80);
        check(irq, 1'b0);
        rd_chk(ca, 8'hc0);
        wr(ma, 8'h12);
        @(posedge core_clk_i);
        cmp_in[ch] <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        #1;
        check(irq, 1'b1);
        check(lat[ch], 1'b0);
        repeat (20) @(posedge core_clk_i);
        rd_chk(ca, 8'h90);
        // Clear lands on the same edge as the rising flag set
        @(posedge core_clk_i);
        cmp_in[ch] <= 1'b1;
        @(posedge core_clk_i);
        wr(ca, 8'h80);
        rd_chk(ca, 8'he0);
        wr(ca, 8'h00);
        check(irq, 1'b0);
        @(posedge core_clk_i);
        cmp_in[ch] <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1;
        check(raw[ch], 1'b0);
        check(lat[ch], 1'b0);
        check(en[ch], 1'b0);
        @(posedge core_clk_i);
        cmp_in[ch] <= 1'b0;
        wr(ma, `MODE_RESET);
    endtask : edge_run

    // ==================================================================
    // Main sequence
    initial begin
        n_errors        = 0;
        checked         = 0;
        rstn_i          = 1'b0;
        sfr_wr_i        = 1'b0;
        sfr_rd_i        = 1'b0;
        sfr_addr_i      = 8'h00;
        sfr_wdata_i     = 8'h00;
        cmp_in          = 2'b00;
        ch0_reset_sel_i = 1'b0;
        repeat (8) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            rd_chk((ch == 1) ? `CH1_CTRL_ADDR : `CH0_CTRL_ADDR, 8'h00);
            rd_chk((ch == 1) ? `CH1_MUX_ADDR : `CH0_MUX_ADDR, 8'h00);
            rd_chk((ch == 1) ? `CH1_MODE_ADDR : `CH0_MODE_ADDR, 8'h02);
            check(sfr_hit_o, 1'b1);
            check(resp[ch], 8'h02);
            check(pos_pin[ch], 8'h01);
            check(neg_pin[ch], 8'h01);
        end
        // Unmapped place: write is dropped and read gives zero
        wr(8'h90, 8'hff);
        check(sfr_hit_o, 1'b0);
        rd_chk(8'h90, 8'h00);
        for (int ch = 0; ch < 2; ch++) begin
            for (int c = 0; c < 4; c++) begin
                wr((ch == 1) ? `CH1_MUX_ADDR : `CH0_MUX_ADDR,
                   {2'b11, 2'(c), 2'b11, 2'(3 - c)});
                check(pos_pin[ch], 8'h01 << (3 - c));
                check(neg_pin[ch], 8'h01 << c);
                rd_chk((ch == 1) ? `CH1_MUX_ADDR : `CH0_MUX_ADDR,
                       {2'b00, 2'(c), 2'b00, 2'(3 - c)});
                wr((ch == 1) ? `CH1_CTRL_ADDR : `CH0_CTRL_ADDR,
                   {4'h4, 2'(c), 2'(3 - c)});
                check(pos_hyst[ch], 8'(c));
                check(neg_hyst[ch], 8'(3 - c));
                rd_chk((ch == 1) ? `CH1_CTRL_ADDR : `CH0_CTRL_ADDR,
                       {4'h0, 2'(c), 2'(3 - c)});
                wr((ch == 1) ? `CH1_MODE_ADDR : `CH0_MODE_ADDR, {6'h33, 2'(c)});
                check(resp[ch], 8'(c));
                rd_chk((ch == 1) ? `CH1_MODE_ADDR : `CH0_MODE_ADDR, 8'(c));
            end
        end
        edge_run(0);
        edge_run(1);
        end_of_test();
    end

    // Guard against a hung sequence
    initial begin
        #2000000;
        n_errors++;
        end_of_test();
    end
endmodule : dual_comparator_control_tb
